//--- src/ioexp_pkg.sv
// Package of constants and carriers for the expander access register block
package ioexp_pkg;

    localparam int          ADDR_W             = 12;
    localparam int          DATA_W             = 32;
    localparam int          PIN_W              = 16;
    localparam int          SEL_W              = 4;
    localparam int          NUM_EXP            = 5;

    // Register offsets (byte addresses)
    localparam logic [11:0] ACCESS_CTRL_OFFSET = 12'h350;
    localparam logic [11:0] INT_STATUS_OFFSET  = 12'h360;
    localparam logic [11:0] INT_MASK_OFFSET    = 12'h364;

    // Field positions in the access control register
    localparam int          PIN_LSB            = 0;
    localparam int          REFRESH_BIT        = 24;
    localparam int          TEST_MODE_BIT      = 25;
    localparam int          SEL_LSB            = 26;
    localparam int          DONE_BIT           = 31;

    // Reset values
    localparam logic [15:0] PIN_RESET          = 16'h0000;
    localparam logic [3:0]  SEL_RESET          = 4'h0;
    localparam logic [31:0] BUS_ZERO           = 32'h0000_0000;

    // Interrupt status bit positions
    localparam int          IRQ_DONE_BIT       = 0;
    localparam int          IRQ_ERR_BIT        = 1;
    localparam int          IRQ_W              = 2;

    // Register bus request carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_s;

    // Transaction request towards the SMBus master engine
    typedef struct packed {
        logic             valid;
        logic             refresh;   // 1: refresh all pins, 0: output update only
        logic [2:0]       expander;
        logic [PIN_W-1:0] outputs;
    } smb_req_s;

    // Completion from the SMBus master engine
    typedef struct packed {
        logic             done;
        logic             error;
        logic [2:0]       expander;
        logic [PIN_W-1:0] inputs;
    } smb_rsp_s;

endpackage : ioexp_pkg

//--- src/exp_sel_decode.sv
// Selector decoder: maps a select code onto an expander index and a legal flag
`timescale 1ns/1ps
module exp_sel_decode
    import ioexp_pkg::*;
(
    input  wire logic [SEL_W-1:0] sel,
    output logic      [2:0]       index,
    output logic                  legal
);

    // Codes 0,1,2,4 are real expanders; everything else is reserved
    always_comb
    begin
        index = sel[2:0];
        legal = (sel == 4'h0) || (sel == 4'h1) || (sel == 4'h2) || (sel == 4'h4);
    end

endmodule : exp_sel_decode

//--- src/pin_image_mem.sv
// Per-expander pin image store with registered read data
`timescale 1ns/1ps
module pin_image_mem
    import ioexp_pkg::*;
#(
    parameter int DEPTH = NUM_EXP,
    parameter int WIDTH = PIN_W
)
(
    input  wire logic             clock,
    input  wire logic             ce,
    input  wire logic             srst,
    input  wire logic             we,
    input  wire logic [2:0]       waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] wmask,
    input  wire logic [2:0]       raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Masked write per entry; read out through a register
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge clock)
            begin
                if (srst)
                    mem_reg[g] <= '0;
                else if (ce && we && (waddr == 3'(g)))
                    mem_reg[g] <= (mem_reg[g] & ~wmask) | (wdata & wmask);
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (srst)
            rdata <= '0;
        else if (ce)
            rdata <= (int'(raddr) < DEPTH) ? mem_reg[raddr] : '0;
    end

endmodule : pin_image_mem

//--- src/expander_access_ctrl.sv
// Expander access control register with SMBus refresh and test-mode override
`timescale 1ns/1ps
//
// Behaviour
// - Each of the sixteen pin value bits maps to one expander input or output.
// - Reads return last fetched inputs and currently supplied outputs of selected expander.
// - Pin value writes are discarded while override test mode is clear.
// - In test mode, selected expander outputs come from software-written pin values.
// - Pin bits that are expander inputs stay read-only, even in test mode.
// - Writing one to refresh starts an SMBus transaction updating all pin values.
// - The refresh request bit always reads as zero.
// - Setting override test mode makes the core-generated outputs disregarded.
// - Selector field picks expander; codes 0,1,2,4 valid, others reserved.
// - In test mode, a pin value write launches an output update transaction.
// - A write-one-to-clear done flag sets when the selected expander's transaction finishes.
module expander_access_ctrl
    import ioexp_pkg::*;
#(
    parameter logic [PIN_W-1:0] INPUT_MASK = 16'h00ff
)
(
    input  wire logic                       clock,
    input  wire logic                       srst,
    input  wire logic                       ce,
    input  wire ioexp_pkg::bus_req_s        bus_req,
    output logic      [ioexp_pkg::DATA_W-1:0] rdata,
    input  wire logic [ioexp_pkg::PIN_W-1:0] core_outputs [ioexp_pkg::NUM_EXP],
    output ioexp_pkg::smb_req_s             smb_req,
    input  wire logic                       smb_ready,
    input  wire ioexp_pkg::smb_rsp_s        smb_rsp,
    output logic                            test_mode,
    output logic                            irq
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ  = 2'b01,
        ST_WAIT = 2'b11
    } xfer_e;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        xfer_e             xfer;
        logic              test_mode;
        logic [SEL_W-1:0]  sel;
        logic              done;
        logic [2:0]        busy_exp;
        logic              busy_refresh;
        logic              pend_refresh;
        logic              pend_update;
        logic [2:0]        pend_exp;
        logic [IRQ_W-1:0]  status;
        logic [IRQ_W-1:0]  mask;
        smb_req_s          req;
        logic              irq;
    } state_s;

    state_s           s_reg;
    state_s           s_next;
    logic [2:0]       sel_index;
    logic             sel_legal;
    logic             mem_we;
    logic [2:0]       mem_waddr;
    logic [PIN_W-1:0] mem_wdata;
    logic [PIN_W-1:0] mem_wmask;
    logic [PIN_W-1:0] image;
    logic [PIN_W-1:0] test_out [NUM_EXP];
    logic             wr_ctrl;
    logic             rd_hit;

    exp_sel_decode u_sel (
        .sel   (s_reg.sel),
        .index (sel_index),
        .legal (sel_legal)
    );

    // Image of each expander: inputs from SMBus, output bits from test-mode pin writes
    pin_image_mem #(
        .DEPTH (NUM_EXP),
        .WIDTH (PIN_W)
    ) u_mem (
        .clock (clock),
        .ce    (ce),
        .srst  (srst),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .wmask (mem_wmask),
        .raddr (sel_index),
        .rdata (image)
    );

    assign wr_ctrl = bus_req.wr && (bus_req.addr == ACCESS_CTRL_OFFSET);

    // Memory write port: a finished error-free transaction loads its inputs; a test-mode
    // write loads only the output bits, so input bits stay read-only
    always_comb
    begin
        mem_we    = 1'b0;
        mem_waddr = smb_rsp.expander;
        mem_wdata = smb_rsp.inputs;
        mem_wmask = INPUT_MASK;
        if (smb_rsp.done && !smb_rsp.error)
        begin
            mem_we = 1'b1;
        end
        else if (wr_ctrl && s_reg.test_mode && sel_legal)
        begin
            mem_we    = 1'b1;
            mem_waddr = sel_index;
            mem_wdata = bus_req.wdata[PIN_LSB +: PIN_W];
            mem_wmask = ~INPUT_MASK;
        end
    end

    // Test values held per expander for the output bits
    genvar g;
    generate
        for (g = 0; g < NUM_EXP; g++)
        begin : g_test
            logic [PIN_W-1:0] tv_reg;
            always_ff @(posedge clock)
            begin
                if (srst)
                    tv_reg <= PIN_RESET;
                else if (ce && wr_ctrl && s_reg.test_mode && sel_legal
                         && (sel_index == 3'(g)))
                    tv_reg <= bus_req.wdata[PIN_LSB +: PIN_W] & ~INPUT_MASK;
            end
            assign test_out[g] = tv_reg;
        end
    endgenerate

    assign rd_hit = bus_req.rd;

    // Register file, transaction sequencing and interrupt logic
    always_comb
    begin
        logic [PIN_W-1:0] outv;
        logic [PIN_W-1:0] live;
        logic             fin;
        logic             launch;
        logic [IRQ_W-1:0] st_set;
        s_next = s_reg;
        outv   = '0;
        live   = '0;
        fin    = 1'b0;
        launch = 1'b0;
        st_set = '0;

        // Outputs shown on read follow what is really driven to the expander
        outv = s_reg.test_mode ? test_out[sel_index] : core_outputs[sel_index];
        live = (image & INPUT_MASK) | (outv & ~INPUT_MASK);

        // Read data stand only in the cycle after the strobe
        s_next.rdata = BUS_ZERO;
        if (rd_hit)
        begin
            unique case (bus_req.addr)
                ACCESS_CTRL_OFFSET:
                begin
                    s_next.rdata[PIN_LSB +: PIN_W]  = sel_legal ? live : PIN_RESET;
                    s_next.rdata[REFRESH_BIT]       = 1'b0;
                    s_next.rdata[TEST_MODE_BIT]     = s_reg.test_mode;
                    s_next.rdata[SEL_LSB +: SEL_W]  = s_reg.sel;
                    s_next.rdata[DONE_BIT]          = s_reg.done;
                end
                INT_STATUS_OFFSET: s_next.rdata[IRQ_W-1:0] = s_reg.status;
                INT_MASK_OFFSET:   s_next.rdata[IRQ_W-1:0] = s_reg.mask;
                default:           s_next.rdata = BUS_ZERO;
            endcase
        end

        // Completion of any transaction; the done flag sets only for the selected expander
        fin = smb_rsp.done && (s_reg.xfer == ST_WAIT);
        if (fin)
        begin
            s_next.xfer = ST_IDLE;
            if (smb_rsp.expander == sel_index)
                s_next.done = 1'b1;
            st_set[IRQ_DONE_BIT]        = 1'b1;
            st_set[IRQ_ERR_BIT]         = smb_rsp.error;
            s_next.status               = s_next.status | st_set;
        end

        // Transaction sequencer towards the SMBus master engine; it runs before the
        // control writes so that a request written in the launch cycle stays pending
        unique case (s_reg.xfer)
            ST_IDLE:
            begin
                launch = s_reg.pend_refresh || s_reg.pend_update;
                if (launch)
                begin
                    s_next.req.valid    = 1'b1;
                    s_next.req.refresh  = s_reg.pend_refresh;
                    s_next.req.expander = s_reg.pend_exp;
                    s_next.req.outputs  = s_reg.test_mode ? test_out[s_reg.pend_exp]
                                                          : core_outputs[s_reg.pend_exp];
                    s_next.busy_exp     = s_reg.pend_exp;
                    s_next.busy_refresh = s_reg.pend_refresh;
                    s_next.pend_refresh = 1'b0;
                    s_next.pend_update  = 1'b0;
                    s_next.xfer         = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (smb_ready)
                begin
                    s_next.req.valid = 1'b0;
                    s_next.xfer      = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
            end
        endcase

        // Control writes; the done flag clears on one, but a set in the same cycle wins
        if (wr_ctrl)
        begin
            s_next.test_mode = bus_req.wdata[TEST_MODE_BIT];
            s_next.sel       = bus_req.wdata[SEL_LSB +: SEL_W];
            if (bus_req.wdata[DONE_BIT] && !(fin && smb_rsp.expander == sel_index))
                s_next.done = 1'b0;
            if (bus_req.wdata[REFRESH_BIT] && sel_legal)
            begin
                s_next.pend_refresh = 1'b1;
                s_next.pend_exp     = sel_index;
            end
            else if (s_reg.test_mode && sel_legal)
            begin
                s_next.pend_update = 1'b1;
                s_next.pend_exp    = sel_index;
            end
        end
        // Status clears on one, but an event landing in the same cycle keeps its bit
        if (bus_req.wr && bus_req.addr == INT_STATUS_OFFSET)
            s_next.status = (s_reg.status & ~bus_req.wdata[IRQ_W-1:0]) | st_set;
        if (bus_req.wr && bus_req.addr == INT_MASK_OFFSET)
            s_next.mask = bus_req.wdata[IRQ_W-1:0];

        s_next.irq = |(s_next.status & s_next.mask);
    end

    // Single state register, frozen while the clock enable is low
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s_reg      <= '0;
            s_reg.xfer <= ST_IDLE;
            s_reg.sel  <= SEL_RESET;
        end
        else if (ce)
            s_reg <= s_next;
    end

    assign rdata     = s_reg.rdata;
    assign smb_req   = s_reg.req;
    assign test_mode = s_reg.test_mode;
    assign irq       = s_reg.irq;

endmodule : expander_access_ctrl

//--- verification/expander_access_asserts.sv
// Port checks for the expander access control block
`timescale 1ns/1ps
module expander_access_asserts
    import ioexp_pkg::*;
(
    input wire logic                clock,
    input wire logic                srst,
    input wire logic                ce,
    input wire ioexp_pkg::bus_req_s bus_req,
    input wire logic [DATA_W-1:0]   rdata,
    input wire logic [PIN_W-1:0]    core_outputs [NUM_EXP],
    input wire ioexp_pkg::smb_req_s smb_req,
    input wire logic                smb_ready,
    input wire ioexp_pkg::smb_rsp_s smb_rsp,
    input wire logic                test_mode,
    input wire logic                irq
);
    logic busy_reg;
    logic mask_reg;
    logic [SEL_W-1:0] sel_reg;
    logic wr_c;
    logic sel_ok;
    logic quiet;
    logic rd_c;
    // Launch checks only hold when no transfer is already under way; a write acts
    // on the selection already in force, not on the code it writes
    assign wr_c   = ce && bus_req.wr && bus_req.addr == ACCESS_CTRL_OFFSET;
    assign rd_c   = bus_req.rd && bus_req.addr == ACCESS_CTRL_OFFSET;
    assign sel_ok = sel_reg inside {4'h0, 4'h1, 4'h2, 4'h4};
    assign quiet  = !busy_reg && !smb_req.valid;
    // Mirror of the engine's busy state and of the done mask bit
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            busy_reg <= 1'b0;
            mask_reg <= 1'b0;
            sel_reg  <= SEL_RESET;
        end
        else
        begin
            if (smb_req.valid && smb_ready)
                busy_reg <= 1'b1;
            if (smb_rsp.done)
                busy_reg <= 1'b0;
            if (ce && bus_req.wr && bus_req.addr == INT_MASK_OFFSET)
                mask_reg <= bus_req.wdata[IRQ_DONE_BIT];
            if (wr_c)
                sel_reg <= bus_req.wdata[SEL_LSB +: SEL_W];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == BUS_ZERO)
        else $error("read data not zero outside a read");
    a_refresh_reads_zero: assert property ($past(rd_c) |-> !rdata[REFRESH_BIT])
        else $error("refresh bit read back as one");
    a_mode_follows: assert property (wr_c && bus_req.wdata[TEST_MODE_BIT] |=> ##[0:1] test_mode)
        else $error("test mode did not follow write");
    a_req_holds: assert property (smb_req.valid && !smb_ready |=> smb_req.valid && $stable(smb_req))
        else $error("request changed before acceptance");
    a_req_drops: assert property (smb_req.valid && smb_ready |=> !smb_req.valid)
        else $error("request stayed after acceptance");
    a_refresh_launch: assert property (wr_c && bus_req.wdata[REFRESH_BIT] && sel_ok && quiet |-> ##2
        smb_req.valid && smb_req.refresh && smb_req.expander == $past(sel_reg[2:0], 2))
        else $error("refresh write launched no request");
    a_no_launch: assert property (wr_c && quiet && (!sel_ok || (!bus_req.wdata[REFRESH_BIT] && !test_mode))
        |=> !smb_req.valid [*2])
        else $error("request launched by an idle write");
    a_done_irq: assert property (smb_rsp.done && mask_reg |-> ##[1:2] irq)
        else $error("unmasked completion raised no interrupt");
    c_refresh: cover property (smb_req.valid && smb_ready && smb_req.refresh);
    c_update: cover property (smb_req.valid && smb_ready && !smb_req.refresh);
    c_irq: cover property ($rose(irq));
endmodule : expander_access_asserts

bind expander_access_ctrl expander_access_asserts i_chk (.clock(clock), .srst(srst), .ce(ce),
    .bus_req(bus_req), .rdata(rdata), .core_outputs(core_outputs), .smb_req(smb_req),
    .smb_ready(smb_ready), .smb_rsp(smb_rsp), .test_mode(test_mode), .irq(irq));

//--- verification/smb_expander_model.sv
// Behavioural SMBus side: accepts a request, then reports completion
`timescale 1ns/1ps
module smb_expander_model
    import ioexp_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire ioexp_pkg::smb_req_s smb_req,
    input  wire logic [3:0]          lat,
    input  wire logic [PIN_W-1:0]    fetch_val,
    output logic                     smb_ready,
    output ioexp_pkg::smb_rsp_s      smb_rsp
);
    logic [3:0] cnt;
    logic       busy;
    // Accept after lat waiting cycles; the transfer itself takes four
    always_ff @(posedge clock)
    begin
        smb_ready     <= 1'b0;
        smb_rsp.done  <= 1'b0;
        smb_rsp.error <= 1'b0;
        // Outside a completion the inputs toggle, so stale data never looks valid
        smb_rsp.inputs <= srst ? 16'h0000 : ~smb_rsp.inputs;
        if (srst)
        begin
            cnt              <= 4'h0;
            busy             <= 1'b0;
            smb_rsp.expander <= 3'h0;
        end
        else if (busy)
        begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h3)
            begin
                cnt            <= 4'h0;
                busy           <= 1'b0;
                smb_rsp.done   <= 1'b1;
                smb_rsp.inputs <= fetch_val;
            end
        end
        else if (smb_req.valid && !smb_ready)
        begin
            cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
            if (cnt == lat)
            begin
                smb_ready        <= 1'b1;
                busy             <= 1'b1;
                smb_rsp.expander <= smb_req.expander;
            end
        end
    end
endmodule : smb_expander_model

//--- verification/tb_top.sv
// Self-checking bench for the expander access control register
`timescale 1ns/1ps
`define CHK(a, e) begin ev = (e); tests_run++; if ((a) !== ev) begin n_errors++; \
    $display("Error at %0t: got %h want %h", $time, (a), ev); end end
module tb_top;
    import ioexp_pkg::*;
    localparam logic [15:0] IN_M = 16'h00ff;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    bus_req_s    bus_req = '0;
    logic [31:0] rdata;
    logic [15:0] core_out [NUM_EXP];
    smb_req_s    smb_req;
    logic        smb_ready;
    smb_rsp_s    smb_rsp;
    logic        test_mode;
    logic        irq;
    logic [3:0]  lat = 4'h0;
    logic [15:0] fetch_val = 16'h0000;
    logic        rd_q = 1'b0;
    logic [31:0] rd_exp [$];
    logic [31:0] req_exp [$];
    logic [31:0] rng = 32'h58;
    logic [31:0] ev;
    int          n_errors = 0;
    int          tests_run = 0;

    expander_access_ctrl #(.INPUT_MASK(IN_M)) i_dut (.clock(clock), .srst(srst), .ce(ce),
        .bus_req(bus_req), .rdata(rdata), .core_outputs(core_out), .smb_req(smb_req),
        .smb_ready(smb_ready), .smb_rsp(smb_rsp), .test_mode(test_mode), .irq(irq));
    smb_expander_model i_exp (.clock(clock), .srst(srst), .smb_req(smb_req), .lat(lat),
        .fetch_val(fetch_val), .smb_ready(smb_ready), .smb_rsp(smb_rsp));

    initial
        forever #4 clock = ~clock;

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs
    function automatic logic [31:0] ctl(logic d, logic [3:0] s, logic t, logic f, logic [15:0] p);
        return {d, 1'b0, s, t, f, 8'h00, p};
    endfunction : ctl
    function automatic logic [31:0] nxt(ref logic [31:0] q [$]);
        return q.size() ? q.pop_front() : 'x;
    endfunction : nxt
    task automatic close_out();
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // One strobe cycle; the next call waits an edge, so strobes never double up
    task automatic bus(logic [11:0] a, logic [31:0] d, logic w);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
    endtask : bus
    task automatic rd(logic [11:0] a, logic [31:0] e);
        rd_exp.push_back(e);
        bus(a, BUS_ZERO, 1'b0);
    endtask : rd
    task automatic wait_done();
        int i;
        for (i = 0; i < 40 && smb_rsp.done !== 1'b1; i++)
            @(posedge clock);
        if (i == 40)
        begin
            n_errors++;
            $display("Error at %0t: no completion", $time);
            close_out();
        end
        repeat (3) @(posedge clock);
    endtask : wait_done

    always @(posedge clock)
        rd_q <= bus_req.rd;
    // Judge results mid-cycle, once the edge's updates have landed
    always @(negedge clock)
    begin
        if (rd_q)
            `CHK(rdata, nxt(rd_exp))
        if (smb_req.valid && smb_ready)
            `CHK({smb_req.refresh, smb_req.expander, smb_req.outputs & ~IN_M}, nxt(req_exp))
    end

    initial
    begin
        logic [31:0] r;
        logic [15:0] p;
        logic [15:0] f1;
        logic        ok;
        foreach (core_out[i])
            core_out[i] = 16'h0000;
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        foreach (core_out[i])
            core_out[i] <= 16'(xs());
        @(posedge clock);
        rd(ACCESS_CTRL_OFFSET, ctl(0, 4'h0, 0, 0, core_out[0] & ~IN_M));
        rd(12'h3f0, BUS_ZERO);
        bus(ACCESS_CTRL_OFFSET, ctl(0, 4'h0, 0, 0, 16'hffff), 1);
        rd(ACCESS_CTRL_OFFSET, ctl(0, 4'h0, 0, 0, core_out[0] & ~IN_M));
        // Refresh select codes 0 to 7, legal and reserved, at random latency
        for (int k = 0; k < 8; k++)
        begin
            r = xs();
            ok = !(k == 3 || k > 4);
            lat <= 4'(r[1:0]);
            fetch_val <= r[31:16];
            if (k == 1)
                f1 = r[31:16];
            p = ok ? (r[31:16] & IN_M) | (core_out[k % 5] & ~IN_M) : 16'h0000;
            if (ok)
                req_exp.push_back({1'b1, 3'(k), core_out[k % 5] & ~IN_M});
            // A write acts on the selection already in force, so select first
            bus(ACCESS_CTRL_OFFSET, ctl(0, 4'(k), 0, 0, 16'h0000), 1);
            bus(ACCESS_CTRL_OFFSET, ctl(0, 4'(k), 0, 1, 16'h0000), 1);
            if (ok)
                wait_done();
            else
                repeat (6) @(posedge clock);
            rd(ACCESS_CTRL_OFFSET, ctl(ok, 4'(k), 0, 0, p));
            bus(ACCESS_CTRL_OFFSET, ctl(1, 4'(k), 0, 0, 16'h0000), 1);
            rd(ACCESS_CTRL_OFFSET, ctl(0, 4'(k), 0, 0, p));
        end
        // Test mode on expander 1 with the done interrupt unmasked
        fetch_val <= f1;
        bus(INT_STATUS_OFFSET, 32'h3, 1);
        bus(INT_MASK_OFFSET, 32'h1, 1);
        rd(INT_MASK_OFFSET, 32'h1);
        `CHK(irq, 1'b0)
        p = 16'(xs());
        // Entering test mode: the pin write beside it still meets the mode clear
        bus(ACCESS_CTRL_OFFSET, ctl(0, 4'h1, 1, 0, p), 1);
        rd(ACCESS_CTRL_OFFSET, ctl(0, 4'h1, 1, 0, f1 & IN_M));
        req_exp.push_back({1'b0, 3'h1, p & ~IN_M});
        bus(ACCESS_CTRL_OFFSET, ctl(0, 4'h1, 1, 0, p), 1);
        wait_done();
        `CHK({test_mode, irq}, 2'b11)
        p = (f1 & IN_M) | (p & ~IN_M);
        rd(INT_STATUS_OFFSET, 32'h1);
        rd(ACCESS_CTRL_OFFSET, ctl(1, 4'h1, 1, 0, p));
        core_out[1] <= ~core_out[1];
        req_exp.push_back({1'b1, 3'h1, p & ~IN_M});
        bus(ACCESS_CTRL_OFFSET, ctl(1, 4'h1, 1, 1, p), 1);
        wait_done();
        rd(ACCESS_CTRL_OFFSET, ctl(1, 4'h1, 1, 0, p));
        bus(INT_MASK_OFFSET, 32'h0, 1);
        repeat (2) @(posedge clock);
        `CHK(irq, 1'b0)
        bus(INT_STATUS_OFFSET, 32'h1, 1);
        rd(INT_STATUS_OFFSET, BUS_ZERO);
        repeat (2) @(posedge clock);
        // A write while the clock enable is low must leave the mask untouched
        ce <= 1'b0;
        bus(INT_MASK_OFFSET, 32'h1, 1);
        ce <= 1'b1;
        rd(INT_MASK_OFFSET, BUS_ZERO);
        repeat (2) @(posedge clock);
        `CHK(rd_exp.size() + req_exp.size(), 0)
        close_out();
    end
endmodule : tb_top
